// ===== rtl/acc_lowpower_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module acc_lowpower_ctrl
    import acc_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic stop3Req,
    input wire logic stopDeepReq,
    input wire logic hwTrigger,
    input wire logic asyncClkTick,
    input wire logic [9:0] analogSample,
    output logic [4:0] channelSelect,
    output logic convActive,
    output logic doneIrq,
    output logic [7:0] pinDigitalDisableOne,
    output logic [7:0] pinDigitalDisableTwo
);

    // ------------------------------------------------------------
    // State record
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] config_;
        logic [7:0] ctrlTwo;
        logic [7:0] ctrlOne;
        logic [9:0] result;
        logic [9:0] cmpValue;
        logic [7:0] pinOne;
        logic [7:0] pinTwo;
        acc_state_type state;
        logic [5:0] phaseCnt;
        logic [2:0] divCnt;
        logic highRead;
        logic inStop3;
        logic [1:0] trigSync;
        logic trigSeen;
        logic [1:0] ackSync;
        logic ackSeen;
        logic [31:0] rdata;
        logic ready;
        logic err;
        logic irq;
    } acc_regs_type;

    acc_regs_type state_reg;
    acc_regs_type state_next;

    logic accessPhase;
    logic convTick;
    logic trigEdge;
    logic asyncSel;
    logic tenBit;
    logic [9:0] sampleMasked;
    logic [10:0] cmpDiff;
    logic cmpHit;
    logic doneTransfer;
    logic [5:0] approxLen;
    logic doneSet;

    // ------------------------------------------------------------
    // Derived combinational terms
    // ------------------------------------------------------------
    assign accessPhase = psel && penable && !state_reg.ready;
    assign asyncSel = state_reg.config_[CFG_CLK_HI:CFG_CLK_LO] == CLK_ASYNC;
    assign tenBit = state_reg.config_[CFG_MODE_HI:CFG_MODE_LO] == MODE_10BIT;
    assign trigEdge = state_reg.trigSync[1] && !state_reg.trigSeen;
    assign approxLen = tenBit ? APPROX_10BIT : APPROX_8BIT;
    // Converter clock: async tick in async mode, else divided bus clock
    always_comb
    begin
        convTick = 1'b0;
        if (asyncSel)
        begin
            convTick = state_reg.ackSync[1] && !state_reg.ackSeen;
        end
        else
        begin
            case (state_reg.config_[CFG_DIV_HI:CFG_DIV_LO])
                2'h0: convTick = 1'b1;
                2'h1: convTick = state_reg.divCnt[0:0] == 1'b1;
                2'h2: convTick = state_reg.divCnt[1:0] == 2'h3;
                default: convTick = state_reg.divCnt == 3'h7;
            endcase
        end
    end

    // Difference against threshold; 8-bit mode drops low two bits
    assign sampleMasked = tenBit ? analogSample : {2'h0, analogSample[9:2]};
    assign cmpDiff = {1'b0, sampleMasked} - {1'b0, state_reg.cmpValue};
    // Borrow means sample below threshold
    assign cmpHit = state_reg.ctrlTwo[CT2_CMP_GT] ? !cmpDiff[10] : cmpDiff[10];
    // Transfer blocked while a 10-bit high byte is half read
    assign doneTransfer = (!state_reg.ctrlTwo[CT2_CMP_EN] || cmpHit)
        && !(tenBit && state_reg.highRead);
    // Result lands in the result bytes this cycle
    assign doneSet = state_reg.state == ST_CONVERT && convTick
        && state_reg.phaseCnt + 6'h1 >= approxLen && doneTransfer;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        state_next.ready = 1'b0;
        state_next.err = 1'b0;
        state_next.trigSync = {state_reg.trigSync[0], hwTrigger};
        state_next.trigSeen = state_reg.trigSync[1];
        state_next.ackSync = {state_reg.ackSync[0], asyncClkTick};
        state_next.ackSeen = state_reg.ackSync[1];
        state_next.divCnt = state_reg.divCnt + 3'h1;
        state_next.inStop3 = stop3Req;

        // Conversion sequencer
        case (state_reg.state)
            ST_IDLE:
            begin
                if (state_reg.ctrlTwo[CT2_HW_TRIG] && trigEdge
                    && state_reg.ctrlOne[CT1_CH_HI:0] != CH_DISABLED)
                begin
                    state_next.state = ST_SAMPLE;
                    state_next.phaseCnt = 6'h0;
                end
            end
            ST_SAMPLE:
            begin
                if (convTick)
                begin
                    state_next.phaseCnt = state_reg.phaseCnt + 6'h1;
                    if (state_reg.phaseCnt + 6'h1 >= (state_reg.config_[CFG_LONG_SAMPLE]
                        ? SAMPLE_LONG : SAMPLE_SHORT))
                    begin
                        state_next.state = ST_CONVERT;
                        state_next.phaseCnt = 6'h0;
                    end
                end
            end
            ST_CONVERT:
            begin
                if (convTick)
                begin
                    state_next.phaseCnt = state_reg.phaseCnt + 6'h1;
                    if (state_reg.phaseCnt + 6'h1 >= approxLen)
                    begin
                        // Completion works in stop3 too when async clock runs
                        state_next.state = ST_IDLE;
                        if (doneTransfer)
                        begin
                            state_next.result = state_reg.ctrlTwo[CT2_CMP_EN]
                                ? cmpDiff[9:0] : sampleMasked;
                            state_next.ctrlOne[CT1_DONE] = 1'b1;
                        end
                        // Blocked: retry unless single compare miss
                        if ((!doneTransfer && !(state_reg.ctrlTwo[CT2_CMP_EN] && !cmpHit))
                            || state_reg.ctrlOne[CT1_CONT])
                        begin
                            state_next.state = ST_SAMPLE;
                            state_next.phaseCnt = 6'h0;
                        end
                    end
                end
            end
            default:
            begin
                state_next.state = ST_IDLE;
            end
        endcase

        // Register bus writes and reads
        if (accessPhase)
        begin
            state_next.ready = 1'b1;
            state_next.rdata = 32'h0;
            if (pwrite)
            begin
                if (paddr == ADDR_CONTROL_ONE)
                begin
                    state_next.ctrlOne = {1'b0, pwdata[6:0]};
                    state_next.state = ST_IDLE;
                    state_next.phaseCnt = 6'h0;
                    if (pwdata[CT1_CH_HI:0] != CH_DISABLED && !state_reg.ctrlTwo[CT2_HW_TRIG])
                    begin
                        state_next.state = ST_SAMPLE;
                    end
                end
                else if (paddr == ADDR_CONTROL_TWO)
                begin
                    state_next.ctrlTwo = pwdata[7:0] & CT2_WR_MASK;
                    state_next.state = ST_IDLE;
                end
                else if (paddr == ADDR_CMP_HIGH)
                begin
                    state_next.cmpValue[9:8] = pwdata[1:0];
                    state_next.state = ST_IDLE;
                end
                else if (paddr == ADDR_CMP_LOW)
                begin
                    state_next.cmpValue[7:0] = pwdata[7:0];
                    state_next.state = ST_IDLE;
                end
                else if (paddr == ADDR_CONFIG)
                begin
                    state_next.config_ = pwdata[7:0];
                    state_next.state = ST_IDLE;
                end
                else if (paddr == ADDR_PIN_ONE)
                begin
                    state_next.pinOne = pwdata[7:0];
                end
                else if (paddr == ADDR_PIN_TWO)
                begin
                    state_next.pinTwo = pwdata[7:0];
                end
                else if (paddr != ADDR_RESULT_HIGH && paddr != ADDR_RESULT_LOW)
                begin
                    state_next.err = 1'b1;
                end
            end
            else
            begin
                if (paddr == ADDR_CONTROL_ONE)
                begin
                    state_next.rdata = {24'h0, state_reg.ctrlOne};
                end
                else if (paddr == ADDR_CONTROL_TWO)
                begin
                    // Active flag live; bits 3:0 always zero
                    state_next.rdata = {24'h0, state_reg.state != ST_IDLE,
                        state_reg.ctrlTwo[6:4], 4'h0};
                end
                else if (paddr == ADDR_RESULT_HIGH)
                begin
                    state_next.rdata = {30'h0, state_reg.result[9:8]};
                    state_next.highRead = 1'b1;
                end
                else if (paddr == ADDR_RESULT_LOW)
                begin
                    state_next.rdata = {24'h0, state_reg.result[7:0]};
                    state_next.highRead = 1'b0;
                    state_next.ctrlOne[CT1_DONE] = 1'b0;
                end
                else if (paddr == ADDR_CMP_HIGH)
                begin
                    state_next.rdata = {30'h0, state_reg.cmpValue[9:8]};
                end
                else if (paddr == ADDR_CMP_LOW)
                begin
                    state_next.rdata = {24'h0, state_reg.cmpValue[7:0]};
                end
                else if (paddr == ADDR_CONFIG)
                begin
                    state_next.rdata = {24'h0, state_reg.config_};
                end
                else if (paddr == ADDR_PIN_ONE)
                begin
                    state_next.rdata = {24'h0, state_reg.pinOne};
                end
                else if (paddr == ADDR_PIN_TWO)
                begin
                    state_next.rdata = {24'h0, state_reg.pinTwo};
                end
                else
                begin
                    state_next.err = 1'b1;
                end
            end
        end

        // Stop3 entry without async clock: abort, results kept
        if (stop3Req && !state_reg.inStop3 && !asyncSel)
        begin
            state_next.state = ST_IDLE;
            state_next.phaseCnt = 6'h0;
        end
        // Held idle while stopped; trigger only counts after exit
        if (stop3Req && !asyncSel)
        begin
            state_next.state = ST_IDLE;
        end

        // Completion wins over a same-cycle low-byte read, else it is lost
        if (doneSet && accessPhase && !pwrite && paddr == ADDR_RESULT_LOW)
        begin
            state_next.ctrlOne[CT1_DONE] = 1'b1;
        end

        state_next.irq = state_next.ctrlOne[CT1_DONE] && state_next.ctrlOne[CT1_IRQ_EN];
    end

    // ------------------------------------------------------------
    // State register; deep stop resets all fields except the trigSync and ackSync synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_reg <= '{config_: CONFIG_RESET, ctrlTwo: ZERO8, ctrlOne: CT1_RESET,
                result: 10'h0, cmpValue: 10'h0, pinOne: ZERO8, pinTwo: ZERO8,
                state: ST_IDLE, phaseCnt: 6'h0, divCnt: 3'h0, highRead: 1'b0,
                inStop3: 1'b0, trigSync: 2'h0, trigSeen: 1'b0, ackSync: 2'h0,
                ackSeen: 1'b0, rdata: 32'h0, ready: 1'b0, err: 1'b0, irq: 1'b0};
        end
        else if (stopDeepReq)
        begin
            // Registers return to reset values and converter stays off
            state_reg <= '{config_: CONFIG_RESET, ctrlTwo: ZERO8, ctrlOne: CT1_RESET,
                result: 10'h0, cmpValue: 10'h0, pinOne: ZERO8, pinTwo: ZERO8,
                state: ST_IDLE, phaseCnt: 6'h0, divCnt: 3'h0, highRead: 1'b0,
                inStop3: 1'b0, trigSync: state_next.trigSync, trigSeen: 1'b0,
                ackSync: state_next.ackSync, ackSeen: 1'b0, rdata: 32'h0,
                ready: 1'b0, err: 1'b0, irq: 1'b0};
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all from flip-flops
    // ------------------------------------------------------------
    assign prdata = state_reg.rdata;
    assign pready = state_reg.ready;
    assign pslverr = state_reg.err;
    assign channelSelect = state_reg.ctrlOne[CT1_CH_HI:0];
    assign convActive = state_reg.state != ST_IDLE;
    assign doneIrq = state_reg.irq;
    assign pinDigitalDisableOne = state_reg.pinOne;
    assign pinDigitalDisableTwo = state_reg.pinTwo;

endmodule // acc_lowpower_ctrl

`default_nettype wire

// ===== rtl/acc_pkg.sv
package acc_pkg;

    // ------------------------------------------------------------
    // Register byte addresses (APB, one word each)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CONTROL_ONE = 8'h00;
    localparam logic [7:0] ADDR_CONTROL_TWO = 8'h04;
    localparam logic [7:0] ADDR_RESULT_HIGH = 8'h08;
    localparam logic [7:0] ADDR_RESULT_LOW = 8'h0c;
    localparam logic [7:0] ADDR_CMP_HIGH = 8'h10;
    localparam logic [7:0] ADDR_CMP_LOW = 8'h14;
    localparam logic [7:0] ADDR_CONFIG = 8'h18;
    localparam logic [7:0] ADDR_PIN_ONE = 8'h1c;
    localparam logic [7:0] ADDR_PIN_TWO = 8'h20;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CFG_LOW_POWER = 7;
    localparam int CFG_DIV_HI = 6;
    localparam int CFG_DIV_LO = 5;
    localparam int CFG_LONG_SAMPLE = 4;
    localparam int CFG_MODE_HI = 3;
    localparam int CFG_MODE_LO = 2;
    localparam int CFG_CLK_HI = 1;
    localparam int CFG_CLK_LO = 0;
    localparam int CT2_ACTIVE = 7;
    localparam int CT2_HW_TRIG = 6;
    localparam int CT2_CMP_EN = 5;
    localparam int CT2_CMP_GT = 4;
    localparam int CT1_DONE = 7;
    localparam int CT1_IRQ_EN = 6;
    localparam int CT1_CONT = 5;
    localparam int CT1_CH_HI = 4;

    // ------------------------------------------------------------
    // Encodings and reset values
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_8BIT = 2'h0;
    localparam logic [1:0] MODE_10BIT = 2'h2;
    localparam logic [1:0] CLK_BUS = 2'h0;
    localparam logic [1:0] CLK_ASYNC = 2'h3;
    localparam logic [4:0] CH_DISABLED = 5'h1f;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [7:0] CT2_WR_MASK = 8'h70;
    localparam logic [7:0] CT1_RESET = 8'h1f;
    localparam logic [7:0] ZERO8 = 8'h00;

    // ------------------------------------------------------------
    // Timing: converter clock cycles per conversion phase
    // ------------------------------------------------------------
    localparam logic [5:0] SAMPLE_SHORT = 6'h04;
    localparam logic [5:0] SAMPLE_LONG = 6'h18;
    localparam logic [5:0] APPROX_8BIT = 6'h10;
    localparam logic [5:0] APPROX_10BIT = 6'h13;

    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b001,
        ST_SAMPLE = 3'b010,
        ST_CONVERT = 3'b100
    } acc_state_type;

endpackage

// ===== bench/acc_lowpower_ctrl_asserts.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Port checker
// ----------------------------------------
module acc_lowpower_ctrl_asserts
    import acc_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic stop3Req,
    input wire logic stopDeepReq,
    input wire logic [4:0] channelSelect,
    input wire logic convActive,
    input wire logic doneIrq,
    input wire logic [7:0] pinDigitalDisableOne
);
    logic take;
    logic asyncSel;
    logic hwTrigSel;

    // First access cycle of a transfer
    assign take = psel && penable && !pready;

    // Shadow of clock source and trigger mode, cleared like the block
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            asyncSel <= 1'b0;
            hwTrigSel <= 1'b0;
        end
        else if (stopDeepReq)
        begin
            asyncSel <= 1'b0;
            hwTrigSel <= 1'b0;
        end
        else if (take && pwrite)
        begin
            if (paddr == ADDR_CONFIG)
                asyncSel <= (pwdata[1:0] == CLK_ASYNC);
            if (paddr == ADDR_CONTROL_TWO)
                hwTrigSel <= pwdata[CT2_HW_TRIG];
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    a_ready_one_wait: assert property (take |=> pready)
        else $error("pready not one cycle after access");
    a_ready_pulse_once: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_unmapped: assert property (take |=> pslverr
        == (paddr > ADDR_PIN_TWO || paddr[1:0] != 2'h0))
        else $error("pslverr wrong for address");
    a_pin_one_write: assert property (
        take && pwrite && paddr == ADDR_PIN_ONE |=> pinDigitalDisableOne == pwdata[7:0])
        else $error("pin control one not written");
    a_chan_write: assert property (
        take && pwrite && paddr == ADDR_CONTROL_ONE |=> channelSelect == pwdata[4:0])
        else $error("channel select not written");
    a_start_conv: assert property (
        take && pwrite && paddr == ADDR_CONTROL_ONE && pwdata[4:0] != 5'h1f
        && !hwTrigSel && !stop3Req |-> ##[1:3] convActive)
        else $error("control one write did not start a conversion");
    a_stop3_abort: assert property ((stop3Req && !asyncSel) [*3] |-> !convActive)
        else $error("conversion not aborted in stop3");
    a_deep_stop_reset: assert property (
        stopDeepReq |=> !convActive && !doneIrq && channelSelect == 5'h1f
        && pinDigitalDisableOne == 8'h00)
        else $error("deep stop did not reset the block");
    a_irq_clear: assert property (
        take && !pwrite && paddr == ADDR_RESULT_LOW && !convActive |-> ##2 !doneIrq)
        else $error("irq not cleared by result low read");
    a_ctl2_reads_zero: assert property (
        take && !pwrite && paddr == ADDR_CONTROL_TWO |=> prdata[3:0] == 4'h0)
        else $error("control two low bits not zero");
endmodule // acc_lowpower_ctrl_asserts

bind acc_lowpower_ctrl acc_lowpower_ctrl_asserts u_chk (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .stop3Req(stop3Req),
    .stopDeepReq(stopDeepReq),
    .channelSelect(channelSelect),
    .convActive(convActive),
    .doneIrq(doneIrq),
    .pinDigitalDisableOne(pinDigitalDisableOne)
);

`default_nettype wire

// ===== bench/acc_lowpower_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Testbench top
// ----------------------------------------
module acc_lowpower_ctrl_tb_top
    import acc_pkg::*;
;
    logic core_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
    logic stop3Req, stopDeepReq, hwTrigger, asyncClkTick, convActive, doneIrq;
    logic [7:0] paddr, pinOne, pinTwo;
    logic [31:0] pwdata, prdata, rdData;
    logic [9:0] analogSample;
    logic [4:0] channelSelect;
    logic [1:0] tickDiv;
    logic rdErr, seen;
    int numErrors, testsRun, cycleCount;

    acc_lowpower_ctrl DUT (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .stop3Req(stop3Req),
        .stopDeepReq(stopDeepReq), .hwTrigger(hwTrigger), .asyncClkTick(asyncClkTick),
        .analogSample(analogSample), .channelSelect(channelSelect),
        .convActive(convActive), .doneIrq(doneIrq),
        .pinDigitalDisableOne(pinOne), .pinDigitalDisableTwo(pinTwo));

    // Clock
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // Slow converter clock, one tick every four cycles; also cuts a hang
    always @(posedge core_clk)
    begin
        tickDiv <= tickDiv + 2'h1;
        asyncClkTick <= tickDiv[1];
        cycleCount++;
        if (cycleCount == 10000)
        begin
            $display("unexpected timeout expected 0 seen 1");
            numErrors++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", testsRun, numErrors);
        if (numErrors == 0 && testsRun > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // One APB transfer; waits for pready, bounded by the cycle ceiling
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1)
            @(posedge core_clk);
        rdData = prdata;
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        testsRun++;
        if (got !== exp)
        begin
            $display("unexpected %s expected %h seen %h", nm, exp, got);
            numErrors++;
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
        xfer(1'b0, a, 32'h0);
        check(nm, exp, rdData);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic wait_done(input int lim);
        int n;
        n = 0;
        seen = 1'b0;
        while (n < lim && !seen)
        begin
            @(posedge core_clk);
            n++;
            seen = (doneIrq === 1'b1);
        end
    endtask

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial
    begin
        {sys_rst, psel, penable, pwrite, stop3Req, stopDeepReq, hwTrigger} = 7'h40;
        {paddr, pwdata, asyncClkTick, tickDiv} = 43'h0;
        analogSample = 10'h2c5;
        numErrors = 0;
        testsRun = 0;
        cycleCount = 0;
        repeat (8) @(posedge core_clk);
        sys_rst <= 1'b0;
        rd(ADDR_CONFIG, 32'h00, "config");
        rd(ADDR_CONTROL_TWO, 32'h00, "control two");
        rd(ADDR_CONTROL_ONE, 32'h1f, "control one");
        $display("test reset values done");
        // Layout, read-only and reserved bits, unmapped place
        wr(ADDR_CONFIG, 32'h98);
        rd(ADDR_CONFIG, 32'h98, "config");
        wr(ADDR_CONTROL_TWO, 32'hfc);
        rd(ADDR_CONTROL_TWO, 32'h70, "control two");
        wr(ADDR_CONTROL_TWO, 32'h00);
        wr(ADDR_PIN_ONE, 32'h02);
        check("pin one", 32'h02, {24'h0, pinOne});
        wr(ADDR_PIN_TWO, 32'h05);
        check("pin two", 32'h05, {24'h0, pinTwo});
        wr(ADDR_CMP_HIGH, 32'h01);
        rd(ADDR_CMP_HIGH, 32'h01, "compare high");
        xfer(1'b0, 8'h40, 32'h0);
        check("slave error", 32'h1, {31'h0, rdErr});
        $display("test layout done");
        // Single 10-bit conversion on the bus clock
        wr(ADDR_CONFIG, 32'h08);
        wr(ADDR_CONTROL_ONE, 32'h41);
        check("channel", 32'h01, {27'h0, channelSelect});
        wait_done(100);
        check("done", 32'h1, {31'h0, seen});
        repeat (40) @(posedge core_clk);
        check("active", 32'h0, {31'h0, convActive});
        rd(ADDR_CONTROL_ONE, 32'hc1, "control one");
        rd(ADDR_RESULT_HIGH, 32'h02, "result high");
        rd(ADDR_RESULT_LOW, 32'hc5, "result low");
        check("irq", 32'h0, {31'h0, doneIrq});
        $display("test conversion done");
        // Stop3 on the bus clock aborts, results stay, no restart
        analogSample <= 10'h155;
        wr(ADDR_CONTROL_ONE, 32'h41);
        repeat (5) @(posedge core_clk);
        stop3Req <= 1'b1;
        repeat (40) @(posedge core_clk);
        check("active", 32'h0, {31'h0, convActive});
        check("irq", 32'h0, {31'h0, doneIrq});
        stop3Req <= 1'b0;
        repeat (60) @(posedge core_clk);
        check("active", 32'h0, {31'h0, convActive});
        rd(ADDR_RESULT_HIGH, 32'h02, "result high");
        rd(ADDR_RESULT_LOW, 32'hc5, "result low");
        $display("test stop3 bus clock done");
        // Stop3 on the slow clock: runs on, then hardware trigger
        wr(ADDR_CONFIG, 32'h0b);
        wr(ADDR_CONTROL_ONE, 32'h41);
        repeat (8) @(posedge core_clk);
        stop3Req <= 1'b1;
        wait_done(400);
        check("done", 32'h1, {31'h0, seen});
        stop3Req <= 1'b0;
        rd(ADDR_RESULT_HIGH, 32'h01, "result high");
        rd(ADDR_RESULT_LOW, 32'h55, "result low");
        analogSample <= 10'h0aa;
        wr(ADDR_CONTROL_TWO, 32'h40);
        wr(ADDR_CONTROL_ONE, 32'h41);
        stop3Req <= 1'b1;
        hwTrigger <= 1'b1;
        repeat (4) @(posedge core_clk);
        hwTrigger <= 1'b0;
        wait_done(400);
        check("done", 32'h1, {31'h0, seen});
        stop3Req <= 1'b0;
        rd(ADDR_RESULT_HIGH, 32'h00, "result high");
        rd(ADDR_RESULT_LOW, 32'haa, "result low");
        $display("test stop3 slow clock done");
        // Compare above and below the threshold 0x100
        wr(ADDR_CONFIG, 32'h08);
        wr(ADDR_CMP_LOW, 32'h00);
        wr(ADDR_CONTROL_TWO, 32'h30);
        analogSample <= 10'h200;
        wr(ADDR_CONTROL_ONE, 32'h41);
        wait_done(100);
        check("done", 32'h1, {31'h0, seen});
        rd(ADDR_RESULT_HIGH, 32'h01, "result high");
        rd(ADDR_RESULT_LOW, 32'h00, "result low");
        analogSample <= 10'h080;
        wr(ADDR_CONTROL_ONE, 32'h41);
        wait_done(100);
        check("done", 32'h0, {31'h0, seen});
        wr(ADDR_CONTROL_TWO, 32'h20);
        wr(ADDR_CONTROL_ONE, 32'h41);
        wait_done(100);
        check("done", 32'h1, {31'h0, seen});
        rd(ADDR_RESULT_HIGH, 32'h03, "result high");
        rd(ADDR_RESULT_LOW, 32'h80, "result low");
        $display("test compare done");
        // Deep stop returns every register to reset
        wr(ADDR_CONFIG, 32'h98);
        wr(ADDR_PIN_ONE, 32'h02);
        stopDeepReq <= 1'b1;
        repeat (2) @(posedge core_clk);
        stopDeepReq <= 1'b0;
        rd(ADDR_CONFIG, 32'h00, "config");
        rd(ADDR_CONTROL_ONE, 32'h1f, "control one");
        rd(ADDR_CMP_HIGH, 32'h00, "compare high");
        check("pin one", 32'h00, {24'h0, pinOne});
        check("pin two", 32'h00, {24'h0, pinTwo});
        $display("test deep stop done");
        // Reprogram: long sample, 8-bit continuous, then 10-bit blocking
        wr(ADDR_CONFIG, 32'h98);
        wr(ADDR_CONTROL_ONE, 32'h41);
        wait_done(100);
        check("done", 32'h1, {31'h0, seen});
        wr(ADDR_CONFIG, 32'h00);
        wr(ADDR_CONTROL_ONE, 32'h61);
        wait_done(100);
        rd(ADDR_RESULT_LOW, 32'h20, "result low");
        wait_done(100);
        check("done", 32'h1, {31'h0, seen});
        wr(ADDR_CONTROL_ONE, 32'h1f);
        check("active", 32'h0, {31'h0, convActive});
        wr(ADDR_CONFIG, 32'h08);
        wr(ADDR_CONTROL_ONE, 32'h41);
        rd(ADDR_RESULT_HIGH, 32'h00, "result high");
        wait_done(100);
        check("done", 32'h0, {31'h0, seen});
        rd(ADDR_RESULT_LOW, 32'h20, "result low");
        wait_done(100);
        rd(ADDR_RESULT_LOW, 32'h80, "result low");
        $display("test reprogram done");
        report_and_stop();
    end
endmodule // acc_lowpower_ctrl_tb_top

`default_nettype wire
